// [alarm_latch_clear_manager.sv]
`include "alarm_defines.svh"
`default_nettype none
module alarm_latch_clear_manager
    import alarm_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Fault causes, one per alarm slot
    input wire logic [`ALARM_COUNT-1:0] alarm_cause,
    // Digital inputs and drive state
    input wire logic alarm_reset_input,
    input wire logic emergency_stop_input,
    input wire logic servo_on,
    input wire logic motion_fwd,
    input wire logic motion_rev,
    // Adjustment and parameter-reset flow
    input wire logic main_io_connector_removed,
    input wire logic auto_adjust_start,
    input wire logic auto_adjust_done,
    input wire logic auto_adjust_ok,
    input wire logic param_reset_done,
    // Alarm outputs
    output logic [`ALARM_COUNT-1:0] alarm_latched,
    output logic alarm_active,
    output logic [11:0] active_alarm_code,
    output logic fw_clear_commit,
    output logic irq
);
    // ----------------------------------------------------------------
    // Alarm table
    // ----------------------------------------------------------------
    function automatic alarm_code_t code_of(input int idx);
        case (idx)
            0: code_of = 12'h001;
            1: code_of = 12'h002;
            2: code_of = 12'h003;
            3: code_of = 12'h004;
            4: code_of = 12'h005;
            5: code_of = 12'h006;
            6: code_of = 12'h007;
            7: code_of = 12'h008;
            8: code_of = 12'h009;
            9: code_of = 12'h010;
            10: code_of = 12'h011;
            11: code_of = 12'h012;
            12: code_of = 12'h013;
            13: code_of = 12'h014;
            14: code_of = 12'h015;
            15: code_of = 12'h016;
            16: code_of = 12'h017;
            17: code_of = 12'h018;
            18: code_of = 12'h019;
            19: code_of = 12'h020;
            20: code_of = 12'h022;
            21: code_of = 12'h023;
            22: code_of = 12'h024;
            23: code_of = 12'h025;
            24: code_of = 12'h026;
            25: code_of = 12'h027;
            26: code_of = 12'h028;
            27: code_of = 12'h029;
            28: code_of = 12'h02D;
            29: code_of = 12'h030;
            30: code_of = 12'h031;
            31: code_of = 12'h035;
            32: code_of = 12'h048;
            33: code_of = 12'h067;
            34: code_of = 12'h083;
            35: code_of = 12'h085;
            36: code_of = 12'h086;
            37: code_of = 12'h099;
            38: code_of = 12'h555;
            39: code_of = 12'h880;
            default: code_of = 12'h000;
        endcase
    endfunction

    function automatic alarm_class_e class_of(input alarm_code_t code);
        case (code)
            12'h003: class_of = CLS_UNDERV;
            12'h004, 12'h011, 12'h024, 12'h025, 12'h026, 12'h027, 12'h028,
            12'h029, 12'h02D, 12'h031, 12'h035: class_of = CLS_POWER;
            12'h012: class_of = CLS_ADJUST;
            12'h013: class_of = CLS_ESTOP;
            12'h014: class_of = CLS_LIMIT_REV;
            12'h015: class_of = CLS_LIMIT_FWD;
            12'h017: class_of = CLS_NVM;
            12'h067: class_of = CLS_AUTO;
            12'h099: class_of = CLS_FW;
            12'h555, 12'h880: class_of = CLS_PERM;
            default: class_of = CLS_RESET;
        endcase
    endfunction

    function automatic logic [`ALARM_IDX_W-1:0] first_set(
        input logic [`ALARM_COUNT-1:0] vec);
        first_set = '0;
        for (int i = `ALARM_COUNT - 1; i >= 0; i--) begin
            if (vec[i]) begin
                first_set = i[`ALARM_IDX_W-1:0];
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // Input edges
    // ----------------------------------------------------------------
    logic reset_in_reg;
    logic servo_on_reg;
    logic reset_edge;
    logic servo_off_edge;
    logic servo_on_edge;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reset_in_reg <= 1'b0;
            servo_on_reg <= 1'b0;
        end else begin
            reset_in_reg <= alarm_reset_input;
            servo_on_reg <= servo_on;
        end
    end

    // A held reset input clears once, so a live fault stays visible
    assign reset_edge = alarm_reset_input && !reset_in_reg;
    assign servo_off_edge = servo_on_reg && !servo_on;
    assign servo_on_edge = servo_on && !servo_on_reg;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [15:0] param_sel_reg;
    logic [15:0] fault_opt_reg;
    logic [`INT_WIDTH-1:0] int_status_reg;
    logic [`INT_WIDTH-1:0] int_mask_reg;
    logic [31:0] rdata_reg;
    logic err_reg;
    logic wr_access;
    logic rd_access;
    logic setup;
    logic mapped;
    logic sel_wr;

    assign setup = psel && !penable;
    assign wr_access = psel && penable && pwrite;
    assign rd_access = psel && penable && !pwrite;
    assign sel_wr = wr_access && paddr == `OFF_PARAM_SEL;
    assign pready = 1'b1;
    assign prdata = rdata_reg;
    assign pslverr = psel && penable && err_reg;

    always_comb begin
        case (paddr)
            `OFF_ALARM_LO, `OFF_ALARM_HI, `OFF_ACTIVE, `OFF_PARAM_SEL,
            `OFF_FAULT_OPT, `OFF_INT_STATUS, `OFF_INT_MASK, `OFF_FLOW: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            param_sel_reg <= `PARAM_RESET_VAL;
            fault_opt_reg <= `FAULT_OPT_RESET_VAL;
            int_mask_reg <= `INT_MASK_RESET_VAL;
        end else if (wr_access) begin
            if (paddr == `OFF_PARAM_SEL) begin
                param_sel_reg <= pwdata[15:0];
            end
            if (paddr == `OFF_FAULT_OPT) begin
                fault_opt_reg <= pwdata[15:0];
            end
            if (paddr == `OFF_INT_MASK) begin
                int_mask_reg <= pwdata[`INT_WIDTH-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Adjustment flow
    // ----------------------------------------------------------------
    adj_state_e adj_state_reg;
    logic adj_clear;
    logic adj_latched;

    assign adj_latched = alarm_latched[`ADJ_ALARM_IDX];
    assign adj_clear = adj_state_reg == ADJ_RUNNING && auto_adjust_done && auto_adjust_ok;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adj_state_reg <= ADJ_IDLE;
        end else begin
            case (adj_state_reg)
                ADJ_IDLE: begin
                    if (adj_latched && main_io_connector_removed) begin
                        adj_state_reg <= ADJ_UNPLUG;
                    end
                end
                ADJ_UNPLUG: begin
                    if (!adj_latched) begin
                        adj_state_reg <= ADJ_IDLE;
                    end else if (auto_adjust_start && main_io_connector_removed) begin
                        adj_state_reg <= ADJ_RUNNING;
                    end
                end
                ADJ_RUNNING: begin
                    if (auto_adjust_done || !main_io_connector_removed) begin
                        adj_state_reg <= ADJ_IDLE;
                    end
                end
                default: adj_state_reg <= ADJ_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Firmware alarm selector sequence
    // ----------------------------------------------------------------
    fw_state_e fw_state_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fw_state_reg <= FW_IDLE;
        end else if (sel_wr) begin
            case (fw_state_reg)
                FW_IDLE: begin
                    if (pwdata[15:0] == `SEL_FIRST_CODE) begin
                        fw_state_reg <= FW_FIRST;
                    end
                end
                FW_FIRST: begin
                    if (pwdata[15:0] == `SEL_SECOND_CODE) begin
                        fw_state_reg <= FW_ARMED;
                    end else if (pwdata[15:0] != `SEL_FIRST_CODE) begin
                        fw_state_reg <= FW_IDLE;
                    end
                end
                FW_ARMED: fw_state_reg <= FW_ARMED;
                default: fw_state_reg <= FW_IDLE;
            endcase
        end
    end

    // Latch stays set until power-up; the commit flag tells boot logic to drop the cause
    assign fw_clear_commit = fw_state_reg == FW_ARMED;

    // ----------------------------------------------------------------
    // Memory alarm start-up handling
    // ----------------------------------------------------------------
    logic servo_seen_reg;
    logic nvm_start_reg;
    logic nvm_reset_seen_reg;
    logic nvm_start_clear;

    assign nvm_start_clear = nvm_reset_seen_reg && servo_on_edge;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            servo_seen_reg <= 1'b0;
            nvm_start_reg <= 1'b0;
            nvm_reset_seen_reg <= 1'b0;
        end else begin
            if (servo_on) begin
                servo_seen_reg <= 1'b1;
            end
            if (alarm_cause[`NVM_ALARM_IDX] && !servo_seen_reg) begin
                nvm_start_reg <= 1'b1;
            end else if (!alarm_latched[`NVM_ALARM_IDX]) begin
                nvm_start_reg <= 1'b0;
            end
            if (nvm_start_reg && param_reset_done) begin
                nvm_reset_seen_reg <= 1'b1;
            end else if (!nvm_start_reg) begin
                nvm_reset_seen_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Alarm slots
    // ----------------------------------------------------------------
    logic [`ALARM_COUNT-1:0] cause_eff;
    logic [`ALARM_COUNT-1:0] latched_reg;

    for (genvar g = 0; g < `ALARM_COUNT; g++) begin : g_slot
        localparam alarm_class_e CLS = class_of(code_of(g));
        // Emergency-stop alarm follows its input directly
        assign cause_eff[g] = (CLS == CLS_ESTOP) ? emergency_stop_input : alarm_cause[g];
        alarm_slot #(
            .CLASS(CLS)
        ) u_slot (
            .pclk(pclk),
            .presetn(presetn),
            .cause(cause_eff[g]),
            .reset_edge(reset_edge),
            .servo_off_edge(servo_off_edge),
            .motion_fwd(motion_fwd),
            .motion_rev(motion_rev),
            .uv_auto(fault_opt_reg[`OPT_UV_AUTO_BIT]),
            .adj_clear(adj_clear),
            .nvm_start_mode(nvm_start_reg),
            .nvm_start_clear(nvm_start_clear),
            .latched(alarm_latched[g])
        );
    end

    // ----------------------------------------------------------------
    // Active code and events
    // ----------------------------------------------------------------
    logic [`INT_WIDTH-1:0] int_set;
    logic adj_done_seen;

    assign adj_done_seen = adj_state_reg == ADJ_RUNNING && auto_adjust_done;
    assign int_set[`INT_NEW_BIT] = |(alarm_latched & ~latched_reg);
    assign int_set[`INT_CLEARED_BIT] = |(latched_reg & ~alarm_latched);
    assign int_set[`INT_FW_ARMED_BIT] = sel_wr && fw_state_reg == FW_FIRST &&
        pwdata[15:0] == `SEL_SECOND_CODE;
    assign int_set[`INT_ADJ_DONE_BIT] = adj_done_seen;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latched_reg <= '0;
            alarm_active <= 1'b0;
            active_alarm_code <= 12'h000;
        end else begin
            latched_reg <= alarm_latched;
            alarm_active <= |alarm_latched;
            active_alarm_code <= (|alarm_latched) ? code_of(int'(first_set(alarm_latched)))
                                                 : 12'h000;
        end
    end

    // Set wins over the read that clears
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_status_reg <= '0;
        end else if (rd_access && paddr == `OFF_INT_STATUS) begin
            int_status_reg <= int_set;
        end else begin
            int_status_reg <= int_status_reg | int_set;
        end
    end

    assign irq = |(int_status_reg & int_mask_reg);

    // ----------------------------------------------------------------
    // Read data, captured in the setup cycle
    // ----------------------------------------------------------------
    logic [63:0] lat_wide;

    assign lat_wide = 64'(alarm_latched);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_reg <= 32'h0000_0000;
            err_reg <= 1'b0;
        end else if (setup) begin
            err_reg <= !mapped;
            case (paddr)
                `OFF_ALARM_LO: rdata_reg <= lat_wide[31:0];
                `OFF_ALARM_HI: rdata_reg <= lat_wide[63:32];
                `OFF_ACTIVE: rdata_reg <= {15'h0000, alarm_active, 4'h0, active_alarm_code};
                `OFF_PARAM_SEL: rdata_reg <= {16'h0000, param_sel_reg};
                `OFF_FAULT_OPT: rdata_reg <= {16'h0000, fault_opt_reg};
                `OFF_INT_STATUS: rdata_reg <= {28'h0000000, int_status_reg | int_set};
                `OFF_INT_MASK: rdata_reg <= {28'h0000000, int_mask_reg};
                `OFF_FLOW: rdata_reg <= {22'h000000, nvm_reset_seen_reg, nvm_start_reg,
                                         1'b0, fw_state_reg, 1'b0, adj_state_reg};
                default: rdata_reg <= 32'h0000_0000;
            endcase
        end
    end
endmodule // alarm_latch_clear_manager
`default_nettype wire

// [alarm_defines.svh]
// Behaviour
// - Alarm-reset input clears reset-class alarms
// - Under-voltage holds until power cycle; option bit2 auto-clears
// - Power-cycle-class alarms ignore the alarm-reset input
// - Adjust alarm clears after unplug then good adjust
// - Emergency-stop alarm clears when its input drops
// - Limit alarms clear on reset, servo-off, backing away
// - Memory alarm: startup needs parameter reset, servo-on
// - Encoder temperature warning clears when temperature normal
// - Firmware alarm: write 30 then 28, clears at power-up
// - Processor-failure alarms have no clear path
// - Overload early warning clears by alarm-reset input
`ifndef ALARM_DEFINES_SVH
`define ALARM_DEFINES_SVH

// ----------------------------------------------------------------
// Alarm table
// ----------------------------------------------------------------
`define ALARM_COUNT 40
`define ALARM_IDX_W 6
`define NVM_ALARM_IDX 6'h10
`define ADJ_ALARM_IDX 6'h0B
`define FW_ALARM_IDX 6'h25

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFF_ALARM_LO 8'h00
`define OFF_ALARM_HI 8'h04
`define OFF_ACTIVE 8'h08
`define OFF_PARAM_SEL 8'h0C
`define OFF_FAULT_OPT 8'h10
`define OFF_INT_STATUS 8'h14
`define OFF_INT_MASK 8'h18
`define OFF_FLOW 8'h1C

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define OPT_UV_AUTO_BIT 2
`define SEL_FIRST_CODE 16'h001E
`define SEL_SECOND_CODE 16'h001C
`define PARAM_RESET_VAL 16'h0000
`define FAULT_OPT_RESET_VAL 16'h0000
`define INT_MASK_RESET_VAL 4'h0
`define INT_NEW_BIT 0
`define INT_CLEARED_BIT 1
`define INT_FW_ARMED_BIT 2
`define INT_ADJ_DONE_BIT 3
`define INT_WIDTH 4
`define ACTIVE_ANY_BIT 16

`endif

// [alarm_pkg.sv]
`include "alarm_defines.svh"
`default_nettype none
package alarm_pkg;
    // ----------------------------------------------------------------
    // Clear classes
    // ----------------------------------------------------------------
    typedef enum logic [10:0] {
        CLS_RESET     = 11'h001,
        CLS_POWER     = 11'h002,
        CLS_UNDERV    = 11'h004,
        CLS_ADJUST    = 11'h008,
        CLS_ESTOP     = 11'h010,
        CLS_LIMIT_FWD = 11'h020,
        CLS_LIMIT_REV = 11'h040,
        CLS_NVM       = 11'h080,
        CLS_AUTO      = 11'h100,
        CLS_FW        = 11'h200,
        CLS_PERM      = 11'h400
    } alarm_class_e;

    typedef enum logic [2:0] {
        ADJ_IDLE    = 3'h1,
        ADJ_UNPLUG  = 3'h2,
        ADJ_RUNNING = 3'h4
    } adj_state_e;

    typedef enum logic [2:0] {
        FW_IDLE  = 3'h1,
        FW_FIRST = 3'h2,
        FW_ARMED = 3'h4
    } fw_state_e;

    typedef logic [11:0] alarm_code_t;
endpackage
`default_nettype wire

// [alarm_slot.sv]
`include "alarm_defines.svh"
`default_nettype none
module alarm_slot
    import alarm_pkg::*;
#(
    parameter alarm_class_e CLASS = CLS_RESET
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Cause and clear events
    input wire logic cause,
    input wire logic reset_edge,
    input wire logic servo_off_edge,
    input wire logic motion_fwd,
    input wire logic motion_rev,
    input wire logic uv_auto,
    input wire logic adj_clear,
    input wire logic nvm_start_mode,
    input wire logic nvm_start_clear,
    // Latched alarm
    output logic latched
);
    logic clear;

    always_comb begin
        case (CLASS)
            CLS_RESET: clear = reset_edge;
            CLS_POWER: clear = 1'b0;
            CLS_UNDERV: clear = uv_auto && !cause;
            CLS_ADJUST: clear = adj_clear;
            CLS_ESTOP: clear = !cause;
            CLS_LIMIT_FWD: clear = reset_edge || servo_off_edge || motion_rev;
            CLS_LIMIT_REV: clear = reset_edge || servo_off_edge || motion_fwd;
            CLS_NVM: clear = nvm_start_mode ? nvm_start_clear : reset_edge;
            CLS_AUTO: clear = !cause;
            CLS_FW: clear = 1'b0;
            CLS_PERM: clear = 1'b0;
            default: clear = 1'b0;
        endcase
    end

    // Cause wins over clear so a live fault re-latches at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latched <= 1'b0;
        end else begin
            latched <= cause || (latched && !clear);
        end
    end
endmodule // alarm_slot
`default_nettype wire

// [alarm_monitor.sv]
`include "alarm_defines.svh"
`default_nettype none
module alarm_monitor (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pslverr,
    // Alarms
    input wire logic [`ALARM_COUNT-1:0] alarm_cause,
    input wire logic alarm_reset_input,
    input wire logic emergency_stop_input,
    input wire logic motion_rev,
    input wire logic [`ALARM_COUNT-1:0] alarm_latched,
    input wire logic alarm_active
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----
    // Checks
    // ----
    AST_SLVERR: assert property (psel && penable |->
        pslverr == !(paddr[1:0] == 2'h0 && paddr <= 8'h1C)) else $error("bad pslverr");
    AST_ACTIVE: assert property (alarm_active == $past(|alarm_latched)) else $error("bad active");
    AST_RST_CLR: assert property ($rose(alarm_reset_input) && !alarm_cause[0]
        |-> ##[1:3] !alarm_latched[0]) else $error("reset class kept");
    AST_OVL_WARN: assert property ($rose(alarm_reset_input) && !alarm_cause[21]
        |-> ##[1:3] !alarm_latched[21]) else $error("early warning kept");
    AST_RELATCH: assert property (alarm_cause[5] [*2] |-> alarm_latched[5])
        else $error("live cause not latched");
    AST_PWR_CLS: assert property (alarm_latched[3] |=> alarm_latched[3])
        else $error("power class cleared");
    AST_PERM: assert property (alarm_latched[38] |=> alarm_latched[38])
        else $error("processor alarm cleared");
    AST_FW_HOLD: assert property (alarm_latched[37] |=> $stable(alarm_latched[37]))
        else $error("firmware alarm cleared");
    AST_ESTOP: assert property (!emergency_stop_input [*2] |-> !alarm_latched[12])
        else $error("estop kept");
    AST_ENC_TEMP: assert property (!alarm_cause[33] [*2] |-> !alarm_latched[33])
        else $error("temp warning kept");
    AST_LIMIT: assert property ((motion_rev && !alarm_cause[14]) [*2]
        |-> !alarm_latched[14]) else $error("limit kept");
endmodule // alarm_monitor
bind alarm_latch_clear_manager alarm_monitor u_alarm_monitor (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .paddr(paddr), .pslverr(pslverr),
    .alarm_cause(alarm_cause), .alarm_reset_input(alarm_reset_input),
    .emergency_stop_input(emergency_stop_input), .motion_rev(motion_rev),
    .alarm_latched(alarm_latched), .alarm_active(alarm_active));
`default_nettype wire

// [host_model.sv]
`include "alarm_defines.svh"
`default_nettype none
module host_model (
    // Clock
    input wire logic pclk,
    // APB master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Controller outputs
    output logic servo_on,
    output logic param_reset_done
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {psel, penable, pwrite, paddr, pwdata, servo_on, param_reset_done} = '0;
    end
    // Fresh edge first, so psel is never driven twice in one step
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 20) begin
                testbench.err_count++;
                testbench.finish_test();
            end
            @(posedge pclk);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic servo_set(input logic v);
        @(posedge pclk);
        servo_on <= v;
    endtask
    task automatic nvm_recover();
        @(posedge pclk);
        param_reset_done <= 1'b1;
        @(posedge pclk);
        param_reset_done <= 1'b0;
        servo_set(1'b1);
    endtask
    task automatic fw_seq();
        logic [31:0] q;
        logic e;
        xfer(1'b1, `OFF_PARAM_SEL, 32'h1E, q, e);
        xfer(1'b1, `OFF_PARAM_SEL, 32'h1C, q, e);
    endtask
endmodule // host_model
`default_nettype wire

// [testbench.sv]
`include "alarm_defines.svh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ari, est, mfwd, mrev;
    logic rem, ast, adn, aok, servo_on, prd, act, fwc, irq, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [`ALARM_COUNT-1:0] cause, lat;
    logic [11:0] code;
    int err_count = 0;
    int num_checks = 0;
    int lst[5] = '{0, 21, 3, 38, 39};
    alarm_latch_clear_manager u_alarm_latch_clear_manager (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .alarm_cause(cause),
        .alarm_reset_input(ari), .emergency_stop_input(est), .servo_on(servo_on),
        .motion_fwd(mfwd), .motion_rev(mrev), .main_io_connector_removed(rem),
        .auto_adjust_start(ast), .auto_adjust_done(adn), .auto_adjust_ok(aok),
        .param_reset_done(prd), .alarm_latched(lat), .alarm_active(act),
        .active_alarm_code(code), .fw_clear_commit(fwc), .irq(irq));
    host_model u_host_model (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .servo_on(servo_on), .param_reset_done(prd));
    // ----
    // Helpers
    // ----
    task automatic chk(input string nm, input logic [40:0] seen, input logic [40:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        u_host_model.xfer(1'b0, a, 32'h0, q, e);
        chk("read", q & m, x);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_host_model.xfer(1'b1, a, d, q, e);
    endtask
    task automatic pulse(input int i);
        cause[i] <= 1'b1;
        cyc(1);
        cause[i] <= 1'b0;
        cyc(2);
    endtask
    // Two cycles high give one clean edge
    task automatic arst();
        ari <= 1'b1;
        cyc(2);
        ari <= 1'b0;
        cyc(3);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    initial begin
        cyc(20000);
        err_count++;
        finish_test();
    end
    // ----
    // Scenarios
    // ----
    initial begin
        {presetn, ari, est, mfwd, mrev, rem, ast, adn, aok} = '0;
        cause = '0;
        cyc(16);
        presetn <= 1'b1;
        cyc(2);
        rd(`OFF_PARAM_SEL, 32'hFFFF, `PARAM_RESET_VAL);
        rd(`OFF_FAULT_OPT, 32'hFFFF, `FAULT_OPT_RESET_VAL);
        rd(`OFF_INT_MASK, 32'hF, `INT_MASK_RESET_VAL);
        u_host_model.xfer(1'b0, 8'h20, 32'h0, q, e);
        chk("unmapped", {e, q}, {1'b1, 32'h0});
        $display("test regs done");
        foreach (lst[k]) pulse(lst[k]);
        chk("irq", irq, 0);
        wr(`OFF_INT_MASK, 32'h1);
        cyc(1);
        chk("irq", irq, 1);
        rd(`OFF_ALARM_LO, 32'hFFFFFFFF, 32'h0020_0009);
        rd(`OFF_ALARM_HI, 32'hFF, 32'hC0);
        rd(`OFF_ACTIVE, 32'h1_0FFF, 32'h1_0001);
        rd(`OFF_INT_STATUS, 32'hF, 32'h1);
        cyc(1);
        chk("irq", irq, 0);
        cause[5] <= 1'b1;
        arst();
        chk("latched", lat & 40'hC0_0020_0029, 40'hC0_0000_0028);
        cause[5] <= 1'b0;
        $display("test reset class done");
        pulse(2);
        arst();
        chk("uv", lat[2], 1);
        wr(`OFF_FAULT_OPT, 32'h4);
        cyc(3);
        chk("uv", lat[2], 0);
        est <= 1'b1;
        cause[33] <= 1'b1;
        cyc(3);
        chk("auto", {lat[33], lat[12]}, 2'h3);
        est <= 1'b0;
        cause[33] <= 1'b0;
        cyc(3);
        chk("auto", {lat[33], lat[12]}, 2'h0);
        $display("test auto clear done");
        pulse(11);
        arst();
        chk("adjust", lat[11], 1);
        rem <= 1'b1;
        cyc(2);
        ast <= 1'b1;
        cyc(1);
        ast <= 1'b0;
        cyc(2);
        {adn, aok} <= 2'h3;
        cyc(1);
        adn <= 1'b0;
        cyc(3);
        chk("adjust", lat[11], 0);
        rem <= 1'b0;
        pulse(16);
        arst();
        chk("nvm", lat[16], 1);
        u_host_model.nvm_recover();
        cyc(3);
        chk("nvm", lat[16], 0);
        $display("test flows done");
        pulse(13);
        pulse(14);
        chk("limit", lat[14:13], 2'h3);
        u_host_model.servo_set(1'b0);
        cyc(3);
        chk("limit", lat[14:13], 2'h0);
        pulse(13);
        pulse(14);
        mrev <= 1'b1;
        cyc(3);
        chk("limit", lat[14:13], 2'h1);
        {mfwd, mrev} <= 2'h2;
        cyc(3);
        chk("limit", lat[13], 0);
        pulse(37);
        u_host_model.fw_seq();
        arst();
        chk("fw", {fwc, lat[37]}, 2'h3);
        rd(`OFF_FLOW, 32'h3FF, 32'h41);
        presetn <= 1'b0;
        cyc(2);
        presetn <= 1'b1;
        cyc(3);
        chk("power", {fwc, lat}, 41'h0);
        $display("test power cycle done");
        finish_test();
    end
endmodule // testbench
`default_nettype wire
